//--- common/swr_map.svh
/*
 Constant map of the status write and soft reset slice: register indices,
 parameter byte values, instruction codes, field positions and reset values.
 Assumes inclusion by bare name from the design files, definitions only.
*/
`ifndef SWR_MAP_SVH
`define SWR_MAP_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define SWR_IDX_CTRL        8'h00
`define SWR_IDX_STATE       8'h01
`define SWR_IDX_NV_COPY     8'h02
`define SWR_IDX_RST_COUNT   8'h03
`define SWR_IDX_PARAM_6C    8'h6C
`define SWR_IDX_PARAM_6D    8'h6D
`define SWR_IDX_PARAM_6E    8'h6E
`define SWR_IDX_PARAM_6F    8'h6F

// ----------------------------------------
// Fixed parameter bytes
// ----------------------------------------
`define SWR_PARAM_6C_VAL    8'hE8
`define SWR_PARAM_6D_VAL    8'h50
`define SWR_PARAM_6E_VAL    8'hC0
`define SWR_PARAM_6F_VAL    8'h80
`define SWR_PARAM_FILL      8'hFF

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define SWR_OP_WR_ENABLE    8'h06
`define SWR_OP_VOL_ENABLE   8'h50
`define SWR_OP_RST_ENABLE   8'h66
`define SWR_OP_RESET        8'h99
`define SWR_OP_WR_STATUS    8'h01
`define SWR_OP_RD_STATUS    8'h05
`define SWR_OP_RD_PARAM     8'h5A

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SWR_STATE_WEL_BIT   8
`define SWR_STATE_VWE_BIT   9
`define SWR_STATE_RSTEN_BIT 10
`define SWR_STATE_VACT_BIT  11
`define SWR_CTRL_RESET      2'b00
`define SWR_NV_RESET        8'h00
`define SWR_ADDR_DUMMY_IDX  2'd3

`endif

//--- common/swr_pkg.sv
/*
 Types shared by the status write and soft reset slice.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package swr_pkg;

   // ----------------------------------------
   // Serial command engine states
   // ----------------------------------------
   typedef enum logic [4:0]
   {
      SWR_S_OPC  = 5'b0_0001,
      SWR_S_WRSR = 5'b0_0010,
      SWR_S_ADDR = 5'b0_0100,
      SWR_S_OUT  = 5'b0_1000,
      SWR_S_SKIP = 5'b1_0000
   } swr_state_type;

   // ----------------------------------------
   // Interface width of the operating mode
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      SWR_W1 = 2'b00,
      SWR_W2 = 2'b01,
      SWR_W4 = 2'b10
   } swr_width_type;

endpackage

`default_nettype wire

//--- logic/swr_core.sv
/*
 Status register 1 copy selection, two-step soft reset and parameter bytes of
 a serial flash, with a classic Wishbone slave for software.
 Assumes the serial pins come from another domain; they are synchronised and
 the serial clock edges are found by the system clock, which must run well
 above twice the serial clock.
*/
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
`include "swr_map.svh"

// Functional notes
// - After power-up status register 1 shows the last value written to its non-volatile copy; here reset reloads that copy with 00h.
// - A non-volatile status write is accepted only after the host sent write enable 06h.
// - After 50h a status write goes to the volatile copy, which then replaces the non-volatile one.
// - The device resets only on reset enable 66h directly followed by reset 99h.
// - Both reset instructions are taken on 1, 2 or 4 lines as the current mode sets.
// - Parameter bytes read back as E8h at 6Ch, 50h at 6Dh, C0h at 6Eh and 80h at 6Fh.
module swr_core
(
   input  wire logic        clk_sys_in,
   input  wire logic        rst_b_in,
   input  wire logic        ce_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [9:0]  wb_adr_in,
   input  wire logic [31:0] wb_dat_in,
   input  wire logic [3:0]  wb_sel_in,
   output logic      [31:0] wb_dat_out,
   output logic             wb_ack_out,
   input  wire logic        spi_sclk_in,
   input  wire logic        spi_cs_b_in,
   input  wire logic [3:0]  spi_dq_in,
   output logic      [3:0]  spi_dq_out,
   output logic      [3:0]  spi_dq_oe_out,
   output logic             soft_rst_out
);

   // ----------------------------------------
   // Decoding: parameter bytes shared by bus and serial side, lane count for the serial side only
   // ----------------------------------------
   function automatic logic [7:0] param_byte(input logic [7:0] idx);
      unique case (idx)
         `SWR_IDX_PARAM_6C : param_byte = `SWR_PARAM_6C_VAL;
         `SWR_IDX_PARAM_6D : param_byte = `SWR_PARAM_6D_VAL;
         `SWR_IDX_PARAM_6E : param_byte = `SWR_PARAM_6E_VAL;
         `SWR_IDX_PARAM_6F : param_byte = `SWR_PARAM_6F_VAL;
         default           : param_byte = `SWR_PARAM_FILL;
      endcase
   endfunction

   function automatic logic [3:0] lanes(input logic [1:0] mode);
      unique case (mode)
         swr_pkg::SWR_W2 : lanes = 4'd2;
         swr_pkg::SWR_W4 : lanes = 4'd4;
         default         : lanes = 4'd1;
      endcase
   endfunction

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic                  sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
   logic                  cs_s1_ff, cs_s2_ff;
   logic [3:0]            dq_s1_ff, dq_s2_ff;
   logic                  ack_ff, nxt_ack;
   logic [31:0]           rdat_ff, nxt_rdat;
   logic [1:0]            mode_ff, nxt_mode;
   swr_pkg::swr_state_type state_ff, nxt_state;
   logic [7:0]            in_sh_ff, nxt_in_sh;
   logic [3:0]            in_cnt_ff, nxt_in_cnt;
   logic [7:0]            out_sh_ff, nxt_out_sh;
   logic [3:0]            out_cnt_ff, nxt_out_cnt;
   logic [23:0]           addr_ff, nxt_addr;
   logic [1:0]            addr_idx_ff, nxt_addr_idx;
   logic                  rd_param_ff, nxt_rd_param;
   logic                  wel_ff, nxt_wel;
   logic                  vwe_ff, nxt_vwe;
   logic                  rst_en_ff, nxt_rst_en;
   logic                  vact_ff, nxt_vact;
   logic [7:0]            vol_sr_ff, nxt_vol_sr;
   logic [7:0]            rst_cnt_ff, nxt_rst_cnt;
   logic                  soft_ff, nxt_soft;
   logic [3:0]            dq_ff, nxt_dq;
   logic [3:0]            oe_ff, nxt_oe;
   logic                  nv_we;
   logic [7:0]            nv_wdata;
   logic [7:0]            nv_rd;
   logic [7:0]            sr_eff;
   logic                  sclk_rise, sclk_fall;
   logic [7:0]            sh_in;
   logic [3:0]            w;
   logic [7:0]            widx;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         sclk_s1_ff <= 1'b0;
         sclk_s2_ff <= 1'b0;
         sclk_s3_ff <= 1'b0;
         cs_s1_ff   <= 1'b1;
         cs_s2_ff   <= 1'b1;
         dq_s1_ff   <= 4'h0;
         dq_s2_ff   <= 4'h0;
      end
      else if (ce_in)
      begin
         sclk_s1_ff <= spi_sclk_in;
         sclk_s2_ff <= sclk_s1_ff;
         sclk_s3_ff <= sclk_s2_ff;
         cs_s1_ff   <= spi_cs_b_in;
         cs_s2_ff   <= cs_s1_ff;
         dq_s1_ff   <= spi_dq_in;
         dq_s2_ff   <= dq_s1_ff;
      end
   end

   // Effective status register: volatile copy only once activated
   assign sr_eff    = vact_ff ? vol_sr_ff : nv_rd;
   assign sclk_rise = sclk_s2_ff & ~sclk_s3_ff;
   assign sclk_fall = ~sclk_s2_ff & sclk_s3_ff;
   assign w         = lanes(mode_ff);
   assign widx      = wb_adr_in[9:2];

   // Shift in one, two or four lines per rising edge
   always_comb
   begin
      unique case (mode_ff)
         swr_pkg::SWR_W2 : sh_in = {in_sh_ff[5:0], dq_s2_ff[1:0]};
         swr_pkg::SWR_W4 : sh_in = {in_sh_ff[3:0], dq_s2_ff};
         default         : sh_in = {in_sh_ff[6:0], dq_s2_ff[0]};
      endcase
   end

   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------
   // One wait state; every address answers, unmapped reads give zero
   always_comb
   begin
      nxt_ack  = wb_cyc_in & wb_stb_in & ~ack_ff;
      nxt_rdat = rdat_ff;
      nxt_mode = mode_ff;
      if (nxt_ack)
      begin
         unique case (widx)
            `SWR_IDX_CTRL      : nxt_rdat = {30'h0000_0000, mode_ff};
            `SWR_IDX_STATE     : nxt_rdat = {20'h0_0000, vact_ff, rst_en_ff, vwe_ff,
                                             wel_ff, sr_eff};
            `SWR_IDX_NV_COPY   : nxt_rdat = {24'h00_0000, nv_rd};
            `SWR_IDX_RST_COUNT : nxt_rdat = {24'h00_0000, rst_cnt_ff};
            `SWR_IDX_PARAM_6C,
            `SWR_IDX_PARAM_6D,
            `SWR_IDX_PARAM_6E,
            `SWR_IDX_PARAM_6F  : nxt_rdat = {24'h00_0000, param_byte(widx)};
            default            : nxt_rdat = 32'h0000_0000;
         endcase
         if (wb_we_in && wb_sel_in[0] && widx == `SWR_IDX_CTRL)
         begin
            // Code 2'b11 is not a width; it is refused and the mode kept
            if (wb_dat_in[1:0] != 2'b11)
               nxt_mode = wb_dat_in[1:0];
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         ack_ff  <= 1'b0;
         rdat_ff <= 32'h0000_0000;
         mode_ff <= `SWR_CTRL_RESET;
      end
      else if (ce_in)
      begin
         ack_ff  <= nxt_ack;
         rdat_ff <= nxt_rdat;
         mode_ff <= nxt_mode;
      end
   end

   // ----------------------------------------
   // Serial command engine
   // ----------------------------------------
   always_comb
   begin
      nxt_state    = state_ff;
      nxt_in_sh    = in_sh_ff;
      nxt_in_cnt   = in_cnt_ff;
      nxt_out_sh   = out_sh_ff;
      nxt_out_cnt  = out_cnt_ff;
      nxt_addr     = addr_ff;
      nxt_addr_idx = addr_idx_ff;
      nxt_rd_param = rd_param_ff;
      nxt_wel      = wel_ff;
      nxt_vwe      = vwe_ff;
      nxt_rst_en   = rst_en_ff;
      nxt_vact     = vact_ff;
      nxt_vol_sr   = vol_sr_ff;
      nxt_rst_cnt  = rst_cnt_ff;
      nxt_soft     = 1'b0;
      nxt_dq       = dq_ff;
      nxt_oe       = oe_ff;
      nv_we        = 1'b0;
      nv_wdata     = sh_in;
      if (cs_s2_ff)
      begin
         // Deselect ends any command and frees the lines
         nxt_state   = swr_pkg::SWR_S_OPC;
         nxt_in_cnt  = 4'd0;
         nxt_out_cnt = 4'd0;
         nxt_oe      = 4'h0;
      end
      else if (sclk_rise)
      begin
         nxt_in_sh  = sh_in;
         nxt_in_cnt = in_cnt_ff + w;
         if (in_cnt_ff + w == 4'd8)
         begin
            nxt_in_cnt = 4'd0;
            unique case (state_ff)
               swr_pkg::SWR_S_OPC :
               begin
                  nxt_rst_en = 1'b0;
                  nxt_state  = swr_pkg::SWR_S_SKIP;
                  unique case (sh_in)
                     `SWR_OP_WR_ENABLE  : nxt_wel = 1'b1;
                     `SWR_OP_VOL_ENABLE : nxt_vwe = 1'b1;
                     `SWR_OP_RST_ENABLE : nxt_rst_en = 1'b1;
                     `SWR_OP_RESET :
                     begin
                        if (rst_en_ff)
                        begin
                           nxt_wel     = 1'b0;
                           nxt_vwe     = 1'b0;
                           nxt_vact    = 1'b0;
                           nxt_soft    = 1'b1;
                           nxt_rst_cnt = rst_cnt_ff + 8'h01;
                        end
                     end
                     `SWR_OP_WR_STATUS :
                     begin
                        // Without either enable the data byte is ignored
                        if (wel_ff || vwe_ff)
                           nxt_state = swr_pkg::SWR_S_WRSR;
                     end
                     `SWR_OP_RD_STATUS :
                     begin
                        nxt_out_sh   = sr_eff;
                        nxt_rd_param = 1'b0;
                        nxt_state    = swr_pkg::SWR_S_OUT;
                     end
                     `SWR_OP_RD_PARAM :
                     begin
                        nxt_addr_idx = 2'd0;
                        nxt_state    = swr_pkg::SWR_S_ADDR;
                     end
                     default : nxt_state = swr_pkg::SWR_S_SKIP;
                  endcase
               end
               swr_pkg::SWR_S_WRSR :
               begin
                  if (vwe_ff)
                  begin
                     nxt_vol_sr = sh_in;
                     nxt_vact   = 1'b1;
                     nxt_vwe    = 1'b0;
                  end
                  else
                  begin
                     nv_we    = 1'b1;
                     nxt_vact = 1'b0;
                     nxt_wel  = 1'b0;
                  end
                  nxt_state = swr_pkg::SWR_S_SKIP;
               end
               swr_pkg::SWR_S_ADDR :
               begin
                  // Three address bytes, then one dummy byte
                  nxt_addr_idx = addr_idx_ff + 2'd1;
                  if (addr_idx_ff == `SWR_ADDR_DUMMY_IDX)
                  begin
                     nxt_out_sh   = (addr_ff[23:8] == 16'h0000) ?
                                    param_byte(addr_ff[7:0]) : `SWR_PARAM_FILL;
                     nxt_rd_param = 1'b1;
                     nxt_state    = swr_pkg::SWR_S_OUT;
                  end
                  else
                     nxt_addr = {addr_ff[15:0], sh_in};
               end
               swr_pkg::SWR_S_OUT,
               swr_pkg::SWR_S_SKIP : nxt_state = state_ff;
            endcase
         end
      end
      else if (sclk_fall && state_ff == swr_pkg::SWR_S_OUT)
      begin
         // Drive on the falling edge so the host samples on the rising one
         unique case (mode_ff)
            swr_pkg::SWR_W2 :
            begin
               nxt_dq = {2'b00, out_sh_ff[7:6]};
               nxt_oe = 4'h3;
            end
            swr_pkg::SWR_W4 :
            begin
               nxt_dq = out_sh_ff[7:4];
               nxt_oe = 4'hF;
            end
            default :
            begin
               nxt_dq = {2'b00, out_sh_ff[7], 1'b0};
               nxt_oe = 4'h2;
            end
         endcase
         nxt_out_sh  = out_sh_ff << w;
         nxt_out_cnt = out_cnt_ff + w;
         if (out_cnt_ff + w == 4'd8)
         begin
            // Status repeats; parameter reads walk up the address
            nxt_out_cnt = 4'd0;
            nxt_addr    = addr_ff + 24'h00_0001;
            nxt_out_sh  = !rd_param_ff ? sr_eff :
                          ((addr_ff[23:8] == 16'h0000 && addr_ff[7:0] != 8'hFF) ?
                           param_byte(addr_ff[7:0] + 8'h01) : `SWR_PARAM_FILL);
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         state_ff    <= swr_pkg::SWR_S_OPC;
         in_sh_ff    <= 8'h00;
         in_cnt_ff   <= 4'd0;
         out_sh_ff   <= 8'h00;
         out_cnt_ff  <= 4'd0;
         addr_ff     <= 24'h00_0000;
         addr_idx_ff <= 2'd0;
         rd_param_ff <= 1'b0;
         wel_ff      <= 1'b0;
         vwe_ff      <= 1'b0;
         rst_en_ff   <= 1'b0;
         vact_ff     <= 1'b0;
         vol_sr_ff   <= 8'h00;
         rst_cnt_ff  <= 8'h00;
         soft_ff     <= 1'b0;
         dq_ff       <= 4'h0;
         oe_ff       <= 4'h0;
      end
      else if (ce_in)
      begin
         state_ff    <= nxt_state;
         in_sh_ff    <= nxt_in_sh;
         in_cnt_ff   <= nxt_in_cnt;
         out_sh_ff   <= nxt_out_sh;
         out_cnt_ff  <= nxt_out_cnt;
         addr_ff     <= nxt_addr;
         addr_idx_ff <= nxt_addr_idx;
         rd_param_ff <= nxt_rd_param;
         wel_ff      <= nxt_wel;
         vwe_ff      <= nxt_vwe;
         rst_en_ff   <= nxt_rst_en;
         vact_ff     <= nxt_vact;
         vol_sr_ff   <= nxt_vol_sr;
         rst_cnt_ff  <= nxt_rst_cnt;
         soft_ff     <= nxt_soft;
         dq_ff       <= nxt_dq;
         oe_ff       <= nxt_oe;
      end
   end

   // ----------------------------------------
   // Non-volatile copy and outputs
   // ----------------------------------------
   swr_nv_store #(
      .WIDTH     (8),
      .RESET_VAL (`SWR_NV_RESET)
   ) u_nv (
      .clk_sys_in  (clk_sys_in),
      .rst_b_in    (rst_b_in),
      .ce_in       (ce_in),
      .wr_en_in    (nv_we),
      .wr_data_in  (nv_wdata),
      .rd_data_out (nv_rd)
   );

   assign wb_dat_out    = rdat_ff;
   assign wb_ack_out    = ack_ff;
   assign spi_dq_out    = dq_ff;
   assign spi_dq_oe_out = oe_ff;
   assign soft_rst_out  = soft_ff;

endmodule // swr_core

`default_nettype wire

//--- logic/swr_nv_store.sv
/*
 Non-volatile copy of status register 1: one word, registered read data.
 Assumes its writer runs on the same clock; power-up is the async reset.
*/
`timescale 1ns/1ns
`default_nettype none

module swr_nv_store
#(
   parameter int          WIDTH     = 8,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
   input  wire logic             clk_sys_in,
   input  wire logic             rst_b_in,
   input  wire logic             ce_in,
   input  wire logic             wr_en_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   output logic      [WIDTH-1:0] rd_data_out
);

   logic [WIDTH-1:0] word_ff;
   logic [WIDTH-1:0] nxt_word;
   logic [WIDTH-1:0] rd_ff;
   logic [WIDTH-1:0] nxt_rd;

   // ----------------------------------------
   // Storage and read register
   // ----------------------------------------
   // Read data lags a write by one cycle, as a real store would
   always_comb
   begin
      nxt_word = wr_en_in ? wr_data_in : word_ff;
      nxt_rd   = word_ff;
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         word_ff <= RESET_VAL;
         rd_ff   <= RESET_VAL;
      end
      else if (ce_in)
      begin
         word_ff <= nxt_word;
         rd_ff   <= nxt_rd;
      end
   end

   assign rd_data_out = rd_ff;

endmodule // swr_nv_store

`default_nettype wire

//--- verif/swr_checker.sv
/*
 Checker for swr_core: bus answer, parameter words, soft reset pulse.
 Assumes it is bound to swr_core and sees its ports only.
*/
`timescale 1ns/1ns
`default_nettype none

module swr_checker
(
   input wire logic        clk_sys_in,
   input wire logic        rst_b_in,
   input wire logic        ce_in,
   input wire logic        wb_cyc_in,
   input wire logic        wb_stb_in,
   input wire logic        wb_we_in,
   input wire logic [9:0]  wb_adr_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [3:0]  wb_sel_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic        wb_ack_out,
   input wire logic        spi_sclk_in,
   input wire logic        spi_cs_b_in,
   input wire logic [3:0]  spi_dq_in,
   input wire logic [3:0]  spi_dq_out,
   input wire logic [3:0]  spi_dq_oe_out,
   input wire logic        soft_rst_out
);
   // ----------------------------------------
   // Properties on the system clock
   // ----------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);
   wire logic [7:0] idx = wb_adr_in[9:2];

   // Fixed parameter word for index 6Ch plus k
   function automatic logic [31:0] pv(input logic [1:0] k);
      return (k == 2'd0) ? 32'h0000_00e8 : (k == 2'd1) ? 32'h0000_0050 :
             (k == 2'd2) ? 32'h0000_00c0 : 32'h0000_0080;
   endfunction

   a_ack_one_pulse: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack stands longer than one cycle");
   a_ack_one_wait: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in |=> wb_ack_out)
      else $error("request not answered after one cycle");
   a_ack_has_cause: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
      else $error("ack without request");
   a_data_holds: assert property (!wb_ack_out |-> $stable(wb_dat_out))
      else $error("read data moved without ack");
   a_param_word: assert property (wb_ack_out && $past(!wb_we_in && idx[7:2] == 6'h1b)
      |-> wb_dat_out == pv($past(idx[1:0])))
      else $error("parameter word wrong");
   a_unmapped_zero: assert property (wb_ack_out && $past(!wb_we_in && idx > 8'h03 && idx[7:2] != 6'h1b)
      |-> wb_dat_out == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_reset_one_pulse: assert property (soft_rst_out |=> !soft_rst_out)
      else $error("soft reset pulse too long");
   a_reset_in_frame: assert property (spi_cs_b_in [*8] |-> !soft_rst_out)
      else $error("soft reset outside a frame");
   a_idle_released: assert property (spi_cs_b_in [*6] |-> spi_dq_oe_out == 4'h0)
      else $error("data lines driven while deselected");
   a_freeze_on_ce: assert property (!ce_in |=> $stable(wb_ack_out) && $stable(wb_dat_out))
      else $error("state moved while clock enable low");
endmodule // swr_checker

bind swr_core swr_checker chk_i (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
   .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
   .wb_dat_in(wb_dat_in), .wb_sel_in(wb_sel_in), .wb_dat_out(wb_dat_out),
   .wb_ack_out(wb_ack_out), .spi_sclk_in(spi_sclk_in), .spi_cs_b_in(spi_cs_b_in),
   .spi_dq_in(spi_dq_in), .spi_dq_out(spi_dq_out), .spi_dq_oe_out(spi_dq_oe_out),
   .soft_rst_out(soft_rst_out));

`default_nettype wire

//--- verif/swr_host_model.sv
/*
 Serial host model: mode 0 frames of 800 ns clock on 1, 2 or 4 lines.
 Assumes the bench resolves the shared data lines and feeds them back.
*/
`timescale 1ns/1ns
`default_nettype none

module swr_host_model
(
   output logic            sclk_out,
   output logic            cs_b_out,
   output logic      [3:0] dq_out,
   input  wire logic [3:0] dq_in
);
   // Idle: clock parked low, deselected
   initial
   begin
      sclk_out = 1'b0;
      cs_b_out = 1'b1;
      dq_out   = 4'ha;
   end

   // One frame; late sampling absorbs the device's synchroniser delay
   task automatic frame(input logic [47:0] d, input int nb, input int w, input bit rd,
                        output logic [7:0] rx);
      int i;
      rx = 8'h00;
      #37 cs_b_out = 1'b0;
      for (i = 8 * nb; i > 0; i -= w)
      begin
         dq_out = 4'(d >> (i - w)) & 4'((1 << w) - 1);
         #400 sclk_out = 1'b1;
         #400 sclk_out = 1'b0;
      end
      dq_out = ~dq_out;
      for (i = 0; i < (rd ? 8 : 0); i += w)
      begin
         #400 sclk_out = 1'b1;
         #300 rx = (rx << w) | 8'(w == 1 ? {3'b000, dq_in[1]} : dq_in & 4'((1 << w) - 1));
         #100 sclk_out = 1'b0;
      end
      #400 cs_b_out = 1'b1;
      dq_out = ~dq_out;
      #800;
   endtask
endmodule // swr_host_model

`default_nettype wire

//--- verif/tb_status_write_and_soft_reset.sv
/*
 Self-checking bench for swr_core beside a behavioural command model.
 Assumes the host model and checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_status_write_and_soft_reset;
   logic        clk_sys_in, rst_b_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
   logic        soft_rst_out, sclk, cs_b, ce_in;
   logic [9:0]  wb_adr_in;
   logic [31:0] wb_dat_in, wb_dat_out, rd;
   logic [3:0]  wb_sel_in, dq_h, dq_d, dq_oe, dq_pin;
   logic [7:0]  rx, b;
   int          fails, n_tests, seed, k, mode, nv, vol, vact, wel, vwe, rsten, rc, npulse, seen;

   // Shared lines: the device wins where it enables, the host drives the rest
   assign dq_pin = (dq_oe & dq_d) | (~dq_oe & dq_h);

   swr_core dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
      .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
      .wb_dat_in(wb_dat_in), .wb_sel_in(wb_sel_in), .wb_dat_out(wb_dat_out),
      .wb_ack_out(wb_ack_out), .spi_sclk_in(sclk), .spi_cs_b_in(cs_b), .spi_dq_in(dq_pin),
      .spi_dq_out(dq_d), .spi_dq_oe_out(dq_oe), .soft_rst_out(soft_rst_out));
   swr_host_model host (.sclk_out(sclk), .cs_b_out(cs_b), .dq_out(dq_h), .dq_in(dq_pin));

   // ----------------------------------------
   // Clock, pulse count, checks and bus cycles
   // ----------------------------------------
   initial
   begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in)
      if (soft_rst_out === 1'b1)
         seen++;

   task automatic complete_run;
      if (fails == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Classic cycle: held until ack, released after it
   task automatic wb(input bit we, input logic [7:0] ix, input logic [31:0] wd,
                     input logic [3:0] sl = 4'hf);
      int n;
      @(posedge clk_sys_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in  <= we;
      wb_adr_in <= {ix, 2'b00};
      wb_dat_in <= wd;
      wb_sel_in <= sl;
      n = 0;
      do
      begin
         @(posedge clk_sys_in);
         n++;
      end
      while (wb_ack_out !== 1'b1 && n < 16);
      rd = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      if (n >= 16)
      begin
         fails++;
         complete_run;
      end
   endtask

   function automatic int eff();
      return vact ? vol : nv;
   endfunction

   function automatic int pb(int a, int dflt);
      case (a)
         8'h6c: return 8'he8;
         8'h6d: return 8'h50;
         8'h6e: return 8'hc0;
         8'h6f: return 8'h80;
         default: return dflt;
      endcase
   endfunction

   task automatic check_regs;
      wb(0, 8'h01, 0);
      chk("state", (vact << 11) | (rsten << 10) | (vwe << 9) | (wel << 8) | eff(), rd);
      wb(0, 8'h02, 0);
      chk("nv_copy", nv, rd);
      wb(0, 8'h03, 0);
      chk("rst_count", rc & 255, rd);
      chk("rst_pulses", npulse, seen);
      wb(0, 8'h00, 0);
      chk("ctrl", mode, rd);
   endtask

   // One frame, then the model follows the opcode
   task automatic cmd(input logic [47:0] d, input int nb, input bit r = 1'b0);
      logic [7:0] op;
      host.frame(d, nb, 1 << mode, r, rx);
      op = 8'(d >> (8 * nb - 8));
      if (op == 8'h99 && rsten)
      begin
         rc++;
         npulse++;
         {wel, vwe, vact} = '0;
      end
      if (op == 8'h06) wel = 1;
      if (op == 8'h50) vwe = 1;
      if (op == 8'h01 && vwe) {vol, vact, vwe} = {32'(d[7:0]), 32'd1, 32'd0};
      else if (op == 8'h01 && wel) {nv, vact, wel} = {32'(d[7:0]), 64'd0};
      rsten = (op == 8'h66);
      check_regs;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      seed = 32'h9e31_0756;
      {rst_b_in, wb_cyc_in, wb_stb_in, wb_we_in, ce_in} = 5'h01;
      {wb_adr_in, wb_dat_in, wb_sel_in} = '0;
      repeat (16) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      check_regs;
      wb(1, 8'h6c, 32'h0000_0000);
      // Parameter area over the bus and the serial read, with edges
      for (k = 8'h6b; k <= 8'h70; k++)
      begin
         wb(0, k[7:0], 0);
         chk("param_word", pb(k, 0), rd);
         cmd({8'h5a, 24'(k), 8'h00}, 5, 1);
         chk("param_serial", pb(k, 8'hff), rx);
      end
      // Refused write, non-volatile write, volatile override
      for (k = 0; k < 3; k++)
      begin
         b = 8'($random(seed));
         cmd({8'h01, b}, 2);
         cmd(8'h06, 1);
         cmd({8'h01, b}, 2);
         cmd(8'h50, 1);
         cmd({8'h01, ~b}, 2);
         cmd(8'h05, 1, 1);
         chk("status_serial", eff(), rx);
      end
      // Broken pair, lone reset, then the pair on every width
      cmd(8'h66, 1);
      cmd(8'h05, 1, 1);
      cmd(8'h99, 1);
      cmd(8'h99, 1);
      wb(1, 8'h00, 1, 4'he);
      for (k = 0; k < 4; k++)
      begin
         wb(1, 8'h00, k);
         mode = (k < 3) ? k : mode;
         cmd(8'h66, 1);
         cmd(8'h99, 1);
         cmd(8'h05, 1, 1);
         chk("status_wide", eff(), rx);
      end
      // Enable low stalls a pending read
      ce_in <= 1'b0;
      fork
         wb(0, 8'h6d, 0);
         begin
            repeat (8) @(posedge clk_sys_in);
            ce_in <= 1'b1;
         end
      join
      chk("ce_hold", pb(8'h6d, 0), rd);
      // Power-up in mid-run: copy restarts at its reset value
      @(posedge clk_sys_in);
      rst_b_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      {mode, nv, vol, vact, wel, vwe, rsten, rc} = '0;
      check_regs;
      complete_run;
   end
endmodule // tb_status_write_and_soft_reset

`default_nettype wire
